// File: common/ssw_pkg.sv
package ssw_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	// reset active time for each variant, in milliseconds
	localparam int unsigned RST_SHORT_MS = 50;
	localparam int unsigned RST_LONG_MS = 200;
	// watchdog timeouts, in milliseconds
	localparam int unsigned WD_FAST_MS = 100;
	localparam int unsigned WD_SLOW_MS = 1600;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned RST_SHORT_CYC = RST_SHORT_MS * CYC_PER_MS;
	localparam int unsigned RST_LONG_CYC = RST_LONG_MS * CYC_PER_MS;
	localparam int unsigned WD_FAST_CYC = WD_FAST_MS * CYC_PER_MS;
	localparam int unsigned WD_SLOW_CYC = WD_SLOW_MS * CYC_PER_MS;
	localparam int CNT_W = 32;
	localparam int SYNC_STAGES = 3;
	// three-level kick input code
	typedef enum logic [1:0] {
		SSW_KICK_LOW,
		SSW_KICK_HIGH,
		SSW_KICK_MID
	} ssw_kick_t;
	localparam logic [1:0] KICK_RST = 2'h2;
endpackage

// File: common/ssw_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssw_sync_if;
	logic raw;
	logic stable;
	modport sync (input raw, output stable);
	modport user (output raw, input stable);
endinterface
`default_nettype wire

// File: rtl/ssw_supervisor.sv
// How it works
// - reset output low while supply low or for one pulse after watchdog expiry.
// - reset stays low for the active time after supply returns.
// - unserviced enabled watchdog gives one reset pulse of active time.
// - larger variants choose the pulse width by a configuration parameter.
// - kick input steady past timeout pulses reset and lowers expired flag.
// - each kick transition restarts the timer; host must toggle in time.
// - kick input at middle level disables the watchdog.
// - power-fail flag low while sense below comparator threshold.
// - supply below backup forces power-fail flag low.
// - guarded select passes through above threshold, forced high below.
// - backup source indicator high while output runs from backup.
// - switched output takes the higher of main and backup supply.
// - expired flag returns high on next transition or on supply low.
// - after any reset the watchdog uses the slow timeout first.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor #(
	parameter int unsigned RST_CYC = ssw_pkg::RST_SHORT_CYC,
	parameter int unsigned WD_FAST_CYC_P = ssw_pkg::WD_FAST_CYC,
	parameter int unsigned WD_SLOW_CYC_P = ssw_pkg::WD_SLOW_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_supply_ok,
	input wire logic i_main_above_backup,
	input wire logic i_power_fail_sense_ok,
	input wire logic [1:0] i_watchdog_kick_input,
	input wire logic i_wd_fast_sel,
	input wire logic i_guarded_select_in_n,
	output logic o_reset_n,
	output logic o_watchdog_expired_flag_n,
	output logic o_power_fail_flag_n,
	output logic o_guarded_select_out_n,
	output logic o_backup_source_active,
	output logic o_main_selected
);
	import ssw_pkg::*;
	localparam int KW = 2;

	////////////////////////////////////////////////////////////////////////
	// three-flop synchronisers on every external input except i_rst
	localparam int NS = 7;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] syn;
	assign raw_in = {i_supply_ok, i_main_above_backup,
		i_power_fail_sense_ok, i_watchdog_kick_input,
		i_wd_fast_sel, i_guarded_select_in_n};
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			ssw_sync_if sif ();
			assign sif.raw = raw_in[gi];
			assign syn[gi] = sif.stable;
			ssw_sync u_sync (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.port_s(sif)
			);
		end
	endgenerate
	wire supply_ok = syn[6];
	wire main_above = syn[5];
	wire pf_ok = syn[4];
	wire [KW-1:0] kick = syn[3:2];
	wire fast_sel = syn[1];
	wire sel_in_n = syn[0];

	////////////////////////////////////////////////////////////////////////
	// watchdog
	logic [CNT_W-1:0] wd_cnt;
	logic [CNT_W-1:0] rst_cnt;
	logic [KW-1:0] kick_prev;
	logic after_reset;
	logic expired_n;
	logic stretching;
	wire wd_enabled = (kick != KICK_RST);
	wire kick_valid = (kick_prev != KICK_RST);
	wire kick_edge = wd_enabled && kick_valid && (kick != kick_prev);
	// slow limit right after any reset, selected limit once kicked
	wire [CNT_W-1:0] wd_limit = (after_reset || !fast_sel) ?
		CNT_W'(WD_SLOW_CYC_P) : CNT_W'(WD_FAST_CYC_P);
	wire wd_hold = stretching || !supply_ok;
	// a kick on the last count still counts as service, so no pulse
	wire wd_fire = wd_enabled && !wd_hold && !kick_edge &&
		(wd_cnt >= wd_limit - 1);
	wire rst_done = (rst_cnt >= CNT_W'(RST_CYC) - 1);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			kick_prev <= KICK_RST;
		end else begin
			kick_prev <= kick;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || !wd_enabled || kick_edge || wd_hold || wd_fire) begin
			wd_cnt <= '0;
		end else begin
			wd_cnt <= wd_cnt + 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || stretching || !supply_ok) begin
			after_reset <= 1'b1;
		end else if (kick_edge) begin
			after_reset <= 1'b0;
		end
	end

	// expired flag: clear on kick edge, low supply or disable wins
	always_ff @(posedge i_mclk) begin
		if (i_rst || !wd_enabled || !supply_ok || kick_edge) begin
			expired_n <= 1'b1;
		end else if (wd_fire) begin
			expired_n <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset stretcher
	always_ff @(posedge i_mclk) begin
		if (i_rst || !supply_ok) begin
			stretching <= 1'b1;
			rst_cnt <= '0;
		end else if (wd_fire) begin
			stretching <= 1'b1;
			rst_cnt <= '0;
		end else if (stretching) begin
			// width fixed by RST_CYC, set per variant
			if (rst_done) begin
				stretching <= 1'b0;
			end else begin
				rst_cnt <= rst_cnt + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all registered
	wire next_reset_n = supply_ok && !stretching && !wd_fire;
	wire next_pf_n = main_above && pf_ok;
	wire next_sel_out_n = supply_ok ? sel_in_n : 1'b1;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_reset_n <= 1'b0;
			o_watchdog_expired_flag_n <= 1'b1;
			o_power_fail_flag_n <= 1'b0;
			o_guarded_select_out_n <= 1'b1;
			o_backup_source_active <= 1'b0;
			o_main_selected <= 1'b1;
		end else begin
			o_reset_n <= next_reset_n;
			o_watchdog_expired_flag_n <= expired_n;
			o_power_fail_flag_n <= next_pf_n;
			o_guarded_select_out_n <= next_sel_out_n;
			o_backup_source_active <= !main_above;
			o_main_selected <= main_above;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_SUPPLY_LOW_RESET: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!supply_ok |=> !o_reset_n)
		else $error("reset not low during low supply");
	AST_STRETCH_HOLD: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		$rose(supply_ok) |=> !o_reset_n [*8])
		else $error("reset released too early after supply");
	AST_FIRE_STRETCH: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		wd_fire |=> stretching && rst_cnt == '0)
		else $error("watchdog fire did not start reset pulse");
	AST_FIRE_HOLD: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		wd_fire |=> !o_reset_n [*8])
		else $error("reset pulse after timeout too short");
	AST_STRETCH_END: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		stretching && rst_done && supply_ok && !wd_fire |=> !stretching)
		else $error("reset pulse did not end at its width");
	AST_EXPIRE_FLAG: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		wd_fire && supply_ok && !kick_edge |=>
			##1 !o_watchdog_expired_flag_n)
		else $error("expired flag not lowered");
	AST_KICK_RESTART: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		kick_edge |=> wd_cnt == '0)
		else $error("kick did not restart timer");
	AST_DISABLED: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!wd_enabled |-> !wd_fire ##1 expired_n)
		else $error("watchdog active while disabled");
	AST_DIS_FLAG_OUT: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!wd_enabled |=> ##1 o_watchdog_expired_flag_n)
		else $error("expired pin low while disabled");
	AST_PF_FLAG: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!main_above |=> !o_power_fail_flag_n)
		else $error("power-fail flag not low on backup");
	AST_PF_SENSE: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		main_above |=> o_power_fail_flag_n == $past(pf_ok))
		else $error("power-fail flag does not follow sense");
	AST_SEL_GATE: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!supply_ok |=> o_guarded_select_out_n)
		else $error("guarded select not forced high");
	AST_SEL_PASS: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		supply_ok |=> o_guarded_select_out_n == $past(sel_in_n))
		else $error("guarded select does not follow input");
	AST_BACKUP_IND: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!main_above |=> o_backup_source_active)
		else $error("backup indicator not raised on backup");
	AST_SEL_SOURCE: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		main_above |=> o_main_selected)
		else $error("main not selected when higher");
	AST_FLAG_CLEAR: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!supply_ok |=> expired_n)
		else $error("expired flag not cleared on low supply");
	AST_KICK_CLEAR: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		kick_edge |=> expired_n)
		else $error("expired flag not cleared on kick");
	AST_LOW_FLAG_OUT: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!supply_ok |=> ##1 o_watchdog_expired_flag_n)
		else $error("expired pin low during low supply");
	AST_SLOW_FIRST: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		stretching |=> after_reset)
		else $error("slow timeout not armed after reset");
endmodule
`default_nettype wire

// File: rtl/ssw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_sync (
	input wire logic i_mclk,
	input wire logic i_rst,
	ssw_sync_if.sync port_s
);
	import ssw_pkg::*;
	logic s1;
	logic s2;
	logic s3;
	logic held;
	// only s2 and s3 are compared, s1 feeds nothing else
	wire agree = (s2 == s3);
	// the pipeline runs through reset and reset loads the settled level,
	// so release shows no false low supply or backup indication
	always_ff @(posedge i_mclk) begin
		s1 <= port_s.raw;
		s2 <= s1;
		s3 <= s2;
		if (i_rst || agree)
			held <= s3;
	end
	assign port_s.stable = held;
endmodule
`default_nettype wire

// File: sim/ssw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model #(
	parameter int PERIOD = 10
) (
	input wire logic i_mclk,
	input wire logic i_service,
	input wire logic i_float,
	output logic [1:0] o_kick
);
	int cnt = 0;
	logic lvl = 1'b0;
	// a stalled host simply stops toggling and holds its last level
	always @(posedge i_mclk) begin
		cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
		if (i_service && cnt == PERIOD - 1)
			lvl <= ~lvl;
	end
	// a released line floats to the middle level
	assign o_kick = i_float ? 2'h2 : {1'b0, lvl};
endmodule
`default_nettype wire

// File: sim/supply_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
	localparam int RC = 20;
	logic i_mclk = 0;
	logic i_rst = 1;
	logic sup = 1;
	logic mab = 1;
	logic pfs = 1;
	logic fsel = 1;
	logic sin = 1;
	logic svc = 0;
	logic flt = 0;
	logic [1:0] kick;
	logic rn, wn, pn, son, bat, msel;
	int miscompares = 0;
	int num_checks = 0;
	int n;

	ssw_host_model #(.PERIOD(10)) host (.i_mclk(i_mclk), .i_service(svc),
		.i_float(flt), .o_kick(kick));
	ssw_supervisor #(.RST_CYC(RC), .WD_FAST_CYC_P(50), .WD_SLOW_CYC_P(200)) dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(sup),
		.i_main_above_backup(mab), .i_power_fail_sense_ok(pfs),
		.i_watchdog_kick_input(kick), .i_wd_fast_sel(fsel),
		.i_guarded_select_in_n(sin), .o_reset_n(rn),
		.o_watchdog_expired_flag_n(wn), .o_power_fail_flag_n(pn),
		.o_guarded_select_out_n(son), .o_backup_source_active(bat),
		.o_main_selected(msel));

	initial forever #2.5 i_mclk = ~i_mclk;

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic got, input logic exp, input string s);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s", $time, s);
		end
	endtask
	task automatic check_range(input int v, input int lo, input int hi,
			input string s);
		check(v >= lo && v <= hi, 1'b1, s);
	endtask
	// sample a step after the edge so registered outputs have landed
	task automatic cyc(input int k);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic wait_rn(input logic lvl, output int k);
		k = 0;
		while (rn !== lvl && k < 1000) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic held_high(input int k, input string s);
		logic bad;
		bad = 1'b0;
		repeat (k) begin
			cyc(1);
			if (rn !== 1'b1)
				bad = 1'b1;
		end
		check(bad, 1'b0, s);
	endtask
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		cyc(8);
		check(rn, 1'b0, "reset out during reset");
		check(son, 1'b1, "select during reset");
		@(posedge i_mclk) i_rst <= 1'b0;
		wait_rn(1'b1, n);
		check_range(n, RC, RC + 4, "stretch after reset");
	endtask
	// fast select is on, yet the first timeout must be the slow one
	task automatic t_wdog();
		held_high(150, "early timeout after reset");
		wait_rn(1'b0, n);
		check_range(n, 0, 100, "no timeout fire");
		cyc(3);
		check(wn, 1'b0, "expired flag not low");
		wait_rn(1'b1, n);
		check_range(n, RC - 3, RC + 4, "pulse width");
		@(posedge i_mclk) svc <= 1'b1;
		cyc(30);
		check(wn, 1'b1, "expired flag kept low");
		held_high(400, "reset while serviced");
		@(posedge i_mclk) flt <= 1'b1;
		held_high(600, "reset while disabled");
		check(wn, 1'b1, "flag while disabled");
	endtask
	task automatic t_supply();
		@(posedge i_mclk) sin <= 1'b0;
		cyc(8);
		check(son, 1'b0, "select not passed");
		@(posedge i_mclk) sup <= 1'b0;
		cyc(8);
		check(rn, 1'b0, "reset on low supply");
		check(son, 1'b1, "select not forced");
		@(posedge i_mclk) sup <= 1'b1;
		wait_rn(1'b1, n);
		check_range(n, RC, RC + 8, "stretch after supply");
	endtask
	task automatic t_pfail();
		@(posedge i_mclk) pfs <= 1'b0;
		cyc(8);
		check(pn, 1'b0, "pf flag high");
		@(posedge i_mclk) pfs <= 1'b1;
		cyc(8);
		check(pn, 1'b1, "pf flag low");
		@(posedge i_mclk) mab <= 1'b0;
		cyc(8);
		check(pn, 1'b0, "pf flag on backup");
		check(bat, 1'b1, "backup flag");
		check(msel, 1'b0, "main selected");
		@(posedge i_mclk) mab <= 1'b1;
		cyc(8);
		check(bat, 1'b0, "backup flag stuck");
		check(msel, 1'b1, "main not selected");
	endtask

	initial begin
		t_reset();
		t_wdog();
		t_supply();
		t_pfail();
		conclude();
	end
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
